// ---- src/clock_monitor_defs.svh ----
`ifndef CLOCK_MONITOR_DEFS_SVH
`define CLOCK_MONITOR_DEFS_SVH

// ==========================================================================
// Register addresses (14-bit register space)
`define ADDR_OPTION      14'h0081
`define ADDR_WDT_CTRL    14'h0105
`define ADDR_OSC_CTRL    14'h008F
`define ADDR_OSC_FAIL    14'h010D
`define ADDR_CONFIG_ONE  14'h2007
`define ADDR_CONFIG_TWO  14'h2008

// ==========================================================================
// Reset values
`define RST_OPTION       8'hFF
`define RST_WDT_CTRL     8'h08
`define RST_OSC_CTRL     8'h00
`define RST_OSC_FAIL     8'h00
`define RST_CONFIG_ONE   8'hFF
`define RST_CONFIG_TWO   8'h03

// ==========================================================================
// Field positions
`define WDT_EN_BIT       0
`define WDT_PS_LSB       1
`define WDT_PS_MSB       4
`define CFG1_FOSC2_BIT   4
`define CFG1_CONFIG_WATCHDOG_ENABLE_BIT   2
`define CFG1_FOSC1_BIT   1
`define CFG1_FOSC0_BIT   0
`define CFG2_FAILSAFE_MONITOR_ENABLE_BIT   0
`define CFG2_TWO_SPEED_STARTUP_ENABLE_BIT    1
`define OSC_SCS_LSB      0
`define OSC_SCS_MSB      1
`define OSC_INTERNAL_OSC_STABLE_BIT     2
`define OSC_STARTUP_COMPLETE_STATUS_BIT     3
`define OSC_INTERNAL_FREQ_SELECT_LSB     4
`define OSC_INTERNAL_FREQ_SELECT_MSB     6
`define FAIL_FLAG_BIT    0
`define FAIL_IE_BIT      1

// ==========================================================================
// Codes and counts
`define FOSC_LP          3'h0
`define FOSC_XT          3'h1
`define FOSC_HS          3'h2
`define SCS_PRIMARY      2'h0
`define SCS_SECONDARY    2'h1
`define SCS_FAILOVER     2'h2
`define WDT_PS_UNITY     4'hC
`define OST_EDGES        1024
`define HOLD_EDGES       8
`define SAMPLE_DIV       64

`endif

// ---- src/clock_monitor_pkg.sv ----
package clock_monitor_pkg;

   // Start-up / run sequence
   typedef enum logic [2:0] {
      ST_BOOT,
      ST_OST,
      ST_EDGE,
      ST_HOLD,
      ST_RUN,
      ST_SLEEP
   } seq_state_t;

   // System clock source steering
   typedef enum logic [2:0] {
      SRC_HOLD,
      SRC_PRIMARY,
      SRC_SECONDARY,
      SRC_INTERNAL_LOWFREQ_RC,
      SRC_INTERNAL_OSCILLATOR_BLOCK
   } sysclk_src_t;

   // Register port request
   typedef struct packed {
      logic [13:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

endpackage

// ---- src/clock_startup_failsafe_monitor.sv ----
`include "clock_monitor_defs.svh"
// Overview of operation
// - Period code doubles 1:32..1:65536, 1100 is 1:1
// - Config enable forces watchdog; else software bit
// - Upper three watchdog control bits read zero
// - Two-speed runs internal RC until crystal stable
// - Start after power-up, wake, reset; reset clears select
// - Two-speed only for the three crystal modes
// - Nonzero frequency field selects oscillator block; stable flag
// - Clock select writable during start-up count
// - Sleep aborts start-up; complete flag stays clear
// - Count 1024 crystal edges, wait RC fall, flag
// - Hold clock low eight crystal falls, then switch
// - Monitor active only when fail-safe enable set
// - Failure flags interrupt, falls back to internal oscillator
// - Reset, sleep or new select ends fail-safe
// - Fail-safe clock follows internal frequency field
// - Sample clock is internal RC divided by 64
// - Latch cleared sample rise, set clock fall, checked
// - Reset in fail-safe with crystal reruns count
// - Reset in fail-safe otherwise returns to primary
// - Fail-safe enable forces two-speed start-up on
// - Keep monitoring after exit; interrupt only if enabled
// - Failure forces select to 10, clears watchdog
// - No primary failure detection while crystal start-up runs; secondary still watched
module clock_startup_failsafe_monitor #(
   parameter int OST_EDGES  = `OST_EDGES,
   parameter int HOLD_EDGES = `HOLD_EDGES
) (
   // Clock and reset
   input  wire logic                       clock_i,
   input  wire logic                       rst_i,
   // Oscillator sense inputs, asynchronous
   input  wire logic                       internal_lowfreq_rc_clk_i,
   input  wire logic                       primary_clk_i,
   input  wire logic                       secondary_clk_i,
   input  wire logic                       internal_oscillator_block_ready_i,
   // Core events, same clock
   input  wire logic                       powerup_done_i,
   input  wire logic                       sleep_i,
   input  wire logic                       wake_i,
   // Register port
   input  wire clock_monitor_pkg::reg_req_t req_i,
   output logic [7:0]                      rd_data_o,
   // Clock steering and watchdog
   output clock_monitor_pkg::sysclk_src_t  sysclk_src_o,
   output logic                            watchdog_run_o,
   output logic                            watchdog_tick_o,
   output logic                            watchdog_clear_o,
   output logic                            osc_fail_irq_o
);

   // ======================================================================
   // Storage
   logic [7:0]                       option_reg;         // Timer option, plain storage
   logic [4:0]                       watchdog_ctrl;      // Period select and enable
   logic [7:0]                       config_one;         // Oscillator mode, watchdog
   logic [1:0]                       config_two;         // Fail-safe and two-speed
   logic [1:0]                       system_clock_select;
   logic [2:0]                       internal_freq_select;
   logic                             startup_complete_status;
   logic                             osc_fail_flag;
   logic                             osc_fail_interrupt_enable;
   logic                             failsafe_active;
   logic                             monitoring_latch;
   logic [5:0]                       sample_cnt;         // Sample clock divider
   logic [$clog2(OST_EDGES)-1:0]     ost_cnt;            // Start-up timer
   logic [$clog2(HOLD_EDGES)-1:0]    hold_cnt;           // Low-hold edge count
   logic [15:0]                      prescale_cnt;       // Watchdog prescaler
   clock_monitor_pkg::seq_state_t    state;

   // ======================================================================
   // Input synchronisers: one per oscillator sense line
   wire  [3:0] async_in = {internal_oscillator_block_ready_i, secondary_clk_i, primary_clk_i, internal_lowfreq_rc_clk_i};
   wire  [3:0] lvl;
   wire  [3:0] rise;
   wire  [3:0] fall;

   for (genvar i = 0; i < 4; i++) begin : g_sync
      logic s1;   // Metastable stage, read only by s2
      logic s2;   // Stable level
      logic s3;   // Previous level for edge detection
      // Two flops before any logic, third for edges
      always_ff @(posedge clock_i or posedge rst_i) begin
         if (rst_i) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
         end else begin
            s1 <= async_in[i];
            s2 <= s1;
            s3 <= s2;
         end
      end
      assign lvl[i]  = s2;
      assign rise[i] = s2 & ~s3;
      assign fall[i] = ~s2 & s3;
   end

   wire internal_lowfreq_rc_rise   = rise[0];
   wire internal_lowfreq_rc_fall   = fall[0];
   wire primary_fall = fall[1];
   wire second_fall  = fall[2];
   wire internal_oscillator_block_ok    = lvl[3];

   // ======================================================================
   // Decodes
   wire [2:0] fosc       = {config_one[`CFG1_FOSC2_BIT], config_one[`CFG1_FOSC1_BIT],
                            config_one[`CFG1_FOSC0_BIT]};
   wire       crystal    = (fosc == `FOSC_LP) || (fosc == `FOSC_XT) || (fosc == `FOSC_HS);
   wire       fcm_en     = config_two[`CFG2_FAILSAFE_MONITOR_ENABLE_BIT];
   // Fail-safe forces two-speed on; non-crystal modes never need it
   wire       two_speed  = crystal && (config_two[`CFG2_TWO_SPEED_STARTUP_ENABLE_BIT] || fcm_en);
   wire       wr_osc     = req_i.wr && (req_i.addr == `ADDR_OSC_CTRL);
   wire [1:0] wr_scs     = req_i.wdata[`OSC_SCS_MSB:`OSC_SCS_LSB];
   wire       in_startup = (state == clock_monitor_pkg::ST_OST) ||
                           (state == clock_monitor_pkg::ST_EDGE);
   wire [3:0] ps_code    = watchdog_ctrl[`WDT_PS_MSB:`WDT_PS_LSB];
   wire       internal_osc_stable       = internal_oscillator_block_ok && (internal_freq_select != 3'h0);

   // ======================================================================
   // Failure detection
   localparam logic [5:0] SAMPLE_HALF = 6'(`SAMPLE_DIV / 2 - 1);
   localparam logic [5:0] SAMPLE_LAST = 6'(`SAMPLE_DIV - 1);
   wire sample_rise = internal_lowfreq_rc_rise && (sample_cnt == SAMPLE_HALF);
   wire sample_fall = internal_lowfreq_rc_rise && (sample_cnt == SAMPLE_LAST);
   // Falling edge of whichever external clock is in use
   wire mon_fall    = (system_clock_select == `SCS_PRIMARY)   ? primary_fall :
                      (system_clock_select == `SCS_SECONDARY) ? second_fall  : 1'b0;
   // Crystal only watched once stable; avoids false trips during start-up
   wire mon_armed   = fcm_en && !failsafe_active &&
                      (((system_clock_select == `SCS_PRIMARY) &&
                        (state == clock_monitor_pkg::ST_RUN)) ||
                       ((system_clock_select == `SCS_SECONDARY) &&
                        (state != clock_monitor_pkg::ST_SLEEP)));
   wire failure     = mon_armed && sample_fall &&
                      !(monitoring_latch || mon_fall);

   // Sample clock divider on internal RC rising edges
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         sample_cnt <= 6'h00;
      end else if (internal_lowfreq_rc_rise) begin
         sample_cnt <= sample_cnt + 6'h01;
      end
   end

   // Monitoring latch: clock edge wins over sample clear
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         monitoring_latch <= 1'b0;
      end else if (mon_fall) begin
         monitoring_latch <= 1'b1;
      end else if (sample_rise) begin
         monitoring_latch <= 1'b0;
      end
   end

   // ======================================================================
   // Start-up sequence
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         state    <= clock_monitor_pkg::ST_BOOT;
         ost_cnt  <= '0;
         hold_cnt <= '0;
      end else if (sleep_i && state != clock_monitor_pkg::ST_BOOT) begin
         state    <= clock_monitor_pkg::ST_SLEEP;
         ost_cnt  <= '0;
      end else begin
         case (state)
            // Power-up timer gates the first start
            clock_monitor_pkg::ST_BOOT: begin
               if (powerup_done_i) begin
                  // Crystal reruns the count, others go straight to primary
                  state <= crystal ? clock_monitor_pkg::ST_OST
                                   : clock_monitor_pkg::ST_RUN;
               end
            end
            clock_monitor_pkg::ST_SLEEP: begin
               if (wake_i) begin
                  state <= crystal ? clock_monitor_pkg::ST_OST
                                   : clock_monitor_pkg::ST_RUN;
               end
            end
            // Count crystal falling edges
            clock_monitor_pkg::ST_OST: begin
               if (primary_fall) begin
                  if (ost_cnt == ($clog2(OST_EDGES))'(OST_EDGES - 1)) begin
                     state   <= clock_monitor_pkg::ST_EDGE;
                     ost_cnt <= '0;
                  end else begin
                     ost_cnt <= ost_cnt + ($clog2(OST_EDGES))'(1);
                  end
               end
            end
            // Align to an internal RC falling edge
            clock_monitor_pkg::ST_EDGE: begin
               if (internal_lowfreq_rc_fall) begin
                  state    <= clock_monitor_pkg::ST_HOLD;
                  hold_cnt <= '0;
               end
            end
            // Clock held low across the crossover
            clock_monitor_pkg::ST_HOLD: begin
               if (primary_fall) begin
                  if (hold_cnt == ($clog2(HOLD_EDGES))'(HOLD_EDGES - 1)) begin
                     state <= clock_monitor_pkg::ST_RUN;
                  end else begin
                     hold_cnt <= hold_cnt + ($clog2(HOLD_EDGES))'(1);
                  end
               end
            end
            clock_monitor_pkg::ST_RUN: begin
               state <= clock_monitor_pkg::ST_RUN;
            end
            default: begin
               state <= clock_monitor_pkg::ST_BOOT;
            end
         endcase
      end
   end

   // Start-up complete flag: only the edge alignment sets it
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         startup_complete_status <= 1'b0;
      end else if (state == clock_monitor_pkg::ST_EDGE && internal_lowfreq_rc_fall && !sleep_i) begin
         startup_complete_status <= 1'b1;
      end else if (sleep_i || state == clock_monitor_pkg::ST_OST) begin
         startup_complete_status <= 1'b0;
      end
   end

   // ======================================================================
   // Clock select, fail-safe condition and fail flag
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         system_clock_select <= `SCS_PRIMARY;
      end else if (failure) begin
         system_clock_select <= `SCS_FAILOVER;
      end else if (wr_osc) begin
         // Accepted in any state, even mid start-up
         system_clock_select <= wr_scs;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         failsafe_active <= 1'b0;
      end else if (failure) begin
         failsafe_active <= 1'b1;
      end else if (sleep_i || (wr_osc && wr_scs != system_clock_select)) begin
         failsafe_active <= 1'b0;
      end
   end

   // Flag is sticky regardless of enable; detection beats a clear
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         osc_fail_flag <= 1'b0;
      end else if (failure) begin
         osc_fail_flag <= 1'b1;
      end else if (req_i.wr && req_i.addr == `ADDR_OSC_FAIL &&
                   req_i.wdata[`FAIL_FLAG_BIT]) begin
         osc_fail_flag <= 1'b0;
      end
   end

   // ======================================================================
   // Software-written registers
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         option_reg                <= `RST_OPTION;
         watchdog_ctrl             <= 5'(`RST_WDT_CTRL);
         config_one                <= `RST_CONFIG_ONE;
         config_two                <= 2'(`RST_CONFIG_TWO);
         internal_freq_select      <= 3'h0;
         osc_fail_interrupt_enable <= 1'b0;
      end else if (req_i.wr) begin
         case (req_i.addr)
            `ADDR_OPTION:     option_reg    <= req_i.wdata;
            `ADDR_WDT_CTRL:   watchdog_ctrl <= req_i.wdata[4:0];
            `ADDR_CONFIG_ONE: config_one    <= req_i.wdata;
            `ADDR_CONFIG_TWO: config_two    <= req_i.wdata[1:0];
            `ADDR_OSC_CTRL:   internal_freq_select <=
                                 req_i.wdata[`OSC_INTERNAL_FREQ_SELECT_MSB:`OSC_INTERNAL_FREQ_SELECT_LSB];
            `ADDR_OSC_FAIL:   osc_fail_interrupt_enable <= req_i.wdata[`FAIL_IE_BIT];
            default: begin
               // Unmapped writes are dropped
            end
         endcase
      end
   end

   // Read data stands for one cycle only; unmapped reads give zero
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         rd_data_o <= 8'h00;
      end else if (req_i.rd) begin
         case (req_i.addr)
            `ADDR_OPTION:     rd_data_o <= option_reg;
            `ADDR_WDT_CTRL:   rd_data_o <= {3'h0, watchdog_ctrl};
            `ADDR_CONFIG_ONE: rd_data_o <= config_one;
            `ADDR_CONFIG_TWO: rd_data_o <= {6'h00, config_two};
            `ADDR_OSC_CTRL:   rd_data_o <= {1'b0, internal_freq_select,
                                            startup_complete_status, internal_osc_stable,
                                            system_clock_select};
            `ADDR_OSC_FAIL:   rd_data_o <= {6'h00, osc_fail_interrupt_enable,
                                            osc_fail_flag};
            default:          rd_data_o <= 8'h00;
         endcase
      end else begin
         rd_data_o <= 8'h00;
      end
   end

   // ======================================================================
   // System clock steering
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         sysclk_src_o <= clock_monitor_pkg::SRC_HOLD;
      end else if (failsafe_active || system_clock_select[1]) begin
         // Internal fallback, frequency from the select field
         sysclk_src_o <= (internal_freq_select != 3'h0) ? clock_monitor_pkg::SRC_INTERNAL_OSCILLATOR_BLOCK
                                                        : clock_monitor_pkg::SRC_INTERNAL_LOWFREQ_RC;
      end else if (system_clock_select == `SCS_SECONDARY) begin
         sysclk_src_o <= (internal_freq_select != 3'h0) ? clock_monitor_pkg::SRC_INTERNAL_OSCILLATOR_BLOCK
                                                        : clock_monitor_pkg::SRC_SECONDARY;
      end else begin
         case (state)
            clock_monitor_pkg::ST_RUN:  sysclk_src_o <= clock_monitor_pkg::SRC_PRIMARY;
            clock_monitor_pkg::ST_OST,
            clock_monitor_pkg::ST_EDGE: sysclk_src_o <= two_speed ? clock_monitor_pkg::SRC_INTERNAL_LOWFREQ_RC
                                                                 : clock_monitor_pkg::SRC_HOLD;
            default:                    sysclk_src_o <= clock_monitor_pkg::SRC_HOLD;
         endcase
      end
   end

   // ======================================================================
   // Watchdog enable and prescaler
   // 17 bits so that the widest division does not wrap
   wire [16:0] ps_limit = (ps_code >= `WDT_PS_UNITY) ? 17'h00000 :
                          (17'h00020 << ps_code) - 17'h00001;
   wire        wdt_en   = config_one[`CFG1_CONFIG_WATCHDOG_ENABLE_BIT] | watchdog_ctrl[`WDT_EN_BIT];

   // Held clear while the start-up timer borrows the count
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         prescale_cnt    <= 16'h0000;
         watchdog_tick_o <= 1'b0;
      end else if (!wdt_en || in_startup || failure) begin
         prescale_cnt    <= 16'h0000;
         watchdog_tick_o <= 1'b0;
      end else if (internal_lowfreq_rc_rise) begin
         watchdog_tick_o <= (prescale_cnt == ps_limit[15:0]);
         prescale_cnt    <= (prescale_cnt == ps_limit[15:0]) ? 16'h0000
                                                             : prescale_cnt + 16'h0001;
      end else begin
         watchdog_tick_o <= 1'b0;
      end
   end

   // Registered status outputs
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         watchdog_run_o   <= 1'b0;
         watchdog_clear_o <= 1'b0;
         osc_fail_irq_o   <= 1'b0;
      end else begin
         watchdog_run_o   <= wdt_en;
         watchdog_clear_o <= failure && wdt_en;
         osc_fail_irq_o   <= osc_fail_flag && osc_fail_interrupt_enable;
      end
   end

endmodule

// ---- tb/clock_monitor_checker_assertions.sv ----
module clock_monitor_checker (
   // Clock and reset
   input wire logic                           clock_i,
   input wire logic                           rst_i,
   // Observed ports
   input wire clock_monitor_pkg::reg_req_t    req_i,
   input wire logic [7:0]                     rd_data_o,
   input wire clock_monitor_pkg::sysclk_src_t sysclk_src_o,
   input wire logic                           watchdog_run_o,
   input wire logic                           watchdog_clear_o,
   input wire logic                           osc_fail_irq_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // One domain; reset silences every check
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   // ==========================================================
   // Register port
   rd_idle_a: assert property (!$past(req_i.rd) |-> rd_data_o == 8'h00)
      else $error("Read data outside its slot");
   wdt_upper_a: assert property ($past(req_i.rd && req_i.addr == 14'h0105)
      |-> rd_data_o[7:5] == 3'h0) else $error("Watchdog control upper bits set");
   run_sw_a: assert property ($past(req_i.wr && req_i.addr == 14'h0105
      && req_i.wdata[0]) |=> watchdog_run_o) else $error("Software enable ignored");
   // ==========================================================
   // Clock steering; primary only after the low hold
   prim_hold_a: assert property (sysclk_src_o == clock_monitor_pkg::SRC_PRIMARY
      && $past(sysclk_src_o) != clock_monitor_pkg::SRC_PRIMARY
      |-> $past(sysclk_src_o) == clock_monitor_pkg::SRC_HOLD) else $error("No hold first");
   fail_src_a: assert property ($rose(osc_fail_irq_o) |-> sysclk_src_o inside
      {clock_monitor_pkg::SRC_INTERNAL_LOWFREQ_RC, clock_monitor_pkg::SRC_INTERNAL_OSCILLATOR_BLOCK})
      else $error("Fail interrupt without fallback");
   // Clear pulse leaves with the failure edge, the steering one cycle later
   clear_src_a: assert property (watchdog_clear_o |=> sysclk_src_o inside
      {clock_monitor_pkg::SRC_INTERNAL_LOWFREQ_RC, clock_monitor_pkg::SRC_INTERNAL_OSCILLATOR_BLOCK})
      else $error("Watchdog clear without fallback");
   clear_pulse_a: assert property (watchdog_clear_o |=> !watchdog_clear_o)
      else $error("Watchdog clear too long");
   // Flag only drops through a software write
   irq_fall_a: assert property ($fell(osc_fail_irq_o) |->
      $past(req_i.wr) || $past(req_i.wr, 2)) else $error("Fail interrupt dropped");
endmodule

bind clock_startup_failsafe_monitor clock_monitor_checker u_chk (
   .clock_i(clock_i), .rst_i(rst_i), .req_i(req_i), .rd_data_o(rd_data_o),
   .sysclk_src_o(sysclk_src_o), .watchdog_run_o(watchdog_run_o),
   .watchdog_clear_o(watchdog_clear_o), .osc_fail_irq_o(osc_fail_irq_o));

// ---- tb/clock_startup_failsafe_monitor_tb.sv ----
module clock_startup_failsafe_monitor_tb;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // Stimulus and observed signals
   logic                           clock_i, rst_i, prun, pwr_ok, slp, rd_d, pclk, wk, iok;
   logic                           run, tick, clr, irq;
   logic [4:0]                     div;      // Slow clocks; RC sped up to save run time
   logic [7:0]                     seed, rdat;
   clock_monitor_pkg::reg_req_t    req;
   clock_monitor_pkg::sysclk_src_t src;
   logic [7:0]                     exp_q[$], msk_q[$];
   int                             err_total, n_tests, k;
   primary_osc_model #(.HALF(4)) u_xtal (.clock_i(clock_i), .run_i(prun), .clk_o(pclk));
   clock_startup_failsafe_monitor #(.OST_EDGES(4), .HOLD_EDGES(2)) u_dut (
      .clock_i(clock_i), .rst_i(rst_i), .internal_lowfreq_rc_clk_i(div[4]), .primary_clk_i(pclk),
      .secondary_clk_i(div[1]), .internal_oscillator_block_ready_i(iok), .powerup_done_i(pwr_ok),
      .sleep_i(slp), .wake_i(wk), .req_i(req), .rd_data_o(rdat), .sysclk_src_o(src),
      .watchdog_run_o(run), .watchdog_tick_o(tick), .watchdog_clear_o(clr),
      .osc_fail_irq_o(irq));
   // ==========================================================
   // Helpers
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      if (err_total == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic wr(input logic [13:0] a, input logic [7:0] d);
      @(posedge clock_i);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge clock_i);
      req <= '0;
   endtask
   // Read: note masked expectation, watcher compares later
   task automatic rd(input logic [13:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge clock_i);
      req <= '{a, 8'h00, 1'b0, 1'b1};
      msk_q.push_back(m);
      exp_q.push_back(e);
      @(posedge clock_i);
      req <= '0;
   endtask
   task automatic wait_src(input clock_monitor_pkg::sysclk_src_t s);
      int k;
      k = 0;
      while (src !== s && k < 6000) begin
         @(negedge clock_i);
         k++;
      end
      chk(8'(src), 8'(s));
   endtask
   // ==========================================================
   // Clocks, read watcher, watchdog
   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end
   always @(posedge clock_i) div <= div + 5'h01;
   always @(posedge clock_i) rd_d <= req.rd;
   always @(negedge clock_i) if (rd_d) chk(rdat & msk_q.pop_front(), exp_q.pop_front());
   initial begin
      repeat (40000) @(posedge clock_i);
      err_total++;
      close_out;
   end
   // ==========================================================
   // Main sequence
   initial begin
      rst_i = 1'b1; req = '0; prun = 1'b1; pwr_ok = 1'b0; slp = 1'b0;
      div = 5'h00; rd_d = 1'b0; seed = 8'h19; err_total = 0; n_tests = 0;
      wk = 1'b0; iok = 1'b0; k = 0;
      repeat (6) @(posedge clock_i);
      rst_i <= 1'b0;
      rd(14'h0105, 8'hFF, 8'h08);
      rd(14'h0081, 8'hFF, 8'hFF);
      rd(14'h3FFF, 8'hFF, 8'h00);
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         wr(14'h0105, seed);
         rd(14'h0105, 8'hFF, seed & 8'h1F);
      end
      wr(14'h2007, 8'hE9);  // XT crystal, config watchdog off
      wr(14'h0105, 8'h18);  // Unity prescale, software off
      repeat (2) @(negedge clock_i);
      chk(8'(run), 8'h00);
      wr(14'h0105, 8'h19);
      repeat (2) @(negedge clock_i);
      chk(8'(run), 8'h01);
      // Unity prescale: one tick per internal RC period of 32 clocks
      while (tick !== 1'b1 && k < 40) begin
         @(negedge clock_i);
         k++;
      end
      k = 0;
      do begin
         @(negedge clock_i);
         k++;
      end while (tick !== 1'b1 && k < 40);
      chk(8'(k), 8'h20);
      wr(14'h010D, 8'h02);  // Fail interrupt enable
      pwr_ok <= 1'b1;
      wait_src(clock_monitor_pkg::SRC_INTERNAL_LOWFREQ_RC);
      rd(14'h008F, 8'h08, 8'h00);
      wait_src(clock_monitor_pkg::SRC_PRIMARY);
      rd(14'h008F, 8'h08, 8'h08);
      prun <= 1'b0;  // Crystal dies
      wait_src(clock_monitor_pkg::SRC_INTERNAL_LOWFREQ_RC);
      rd(14'h008F, 8'h03, 8'h02);
      rd(14'h010D, 8'h01, 8'h01);
      chk(8'(irq), 8'h01);
      wr(14'h010D, 8'h03);
      rd(14'h010D, 8'h03, 8'h02);
      // Same select keeps fail-safe; frequency field picks the block
      wr(14'h008F, 8'h12);
      wait_src(clock_monitor_pkg::SRC_INTERNAL_OSCILLATOR_BLOCK);
      rd(14'h008F, 8'h04, 8'h00);
      iok <= 1'b1;
      repeat (2) @(posedge clock_i);
      rd(14'h008F, 8'h04, 8'h04);
      wr(14'h008F, 8'h01);
      wait_src(clock_monitor_pkg::SRC_SECONDARY);
      chk(8'(irq), 8'h00);
      // Reset mid-run, crystal never starts
      @(posedge clock_i);
      rst_i <= 1'b1;
      pwr_ok <= 1'b0;
      repeat (2) @(posedge clock_i);
      rst_i <= 1'b0;
      rd(14'h008F, 8'h0B, 8'h00);
      wr(14'h2007, 8'hE9);
      wr(14'h010D, 8'h02);
      pwr_ok <= 1'b1;
      wait_src(clock_monitor_pkg::SRC_INTERNAL_LOWFREQ_RC);
      repeat (5000) @(posedge clock_i);
      chk(8'(irq), 8'h00);
      slp <= 1'b1;
      @(posedge clock_i);
      slp <= 1'b0;
      wait_src(clock_monitor_pkg::SRC_HOLD);
      rd(14'h008F, 8'h08, 8'h00);
      repeat (2) @(posedge clock_i);
      // Wake restarts the crystal count on the internal RC
      wk <= 1'b1;
      @(posedge clock_i);
      wk <= 1'b0;
      wait_src(clock_monitor_pkg::SRC_INTERNAL_LOWFREQ_RC);
      repeat (2) @(posedge clock_i);
      close_out;
   end
endmodule

// ---- tb/primary_osc_model.sv ----
module primary_osc_model #(
   parameter int HALF = 4
) (
   // Reference clock and run control
   input  wire logic clock_i,
   input  wire logic run_i,
   // Crystal output
   output logic      clk_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt;  // Half-period count
   // A dead crystal freezes at its last level, never toggles
   initial begin
      clk_o = 1'b0;
      cnt = 0;
   end
   always @(posedge clock_i) begin
      if (run_i) begin
         cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
         if (cnt == HALF - 1) clk_o <= ~clk_o;
      end
   end
endmodule
